// ===== ncmd_regs.svh
// Purpose: register offsets, field positions and reset values of the
//          neutral current mismatch detector
// Assumes: word-wide register port behind the serial interface
// Notes:   definitions only
`ifndef NCMD_REGS_SVH
`define NCMD_REGS_SVH

`define NCMD_ADDR_SUM 16'h0001
`define NCMD_ADDR_THR 16'h0002
`define NCMD_ADDR_FIRST_STATUS 16'h0003
`define NCMD_ADDR_SECOND_STATUS 16'h0004
`define NCMD_ADDR_SECOND_MASK 16'h0005

`define NCMD_DONE_BIT 17
`define NCMD_MIS_BIT 20

`define NCMD_THR_RESET 24'h000000
`define NCMD_SUM_RESET 28'h0000000
`define NCMD_PAD4 4'h0

`endif

// ===== ncmd_pkg.sv
// Purpose: shared types of the neutral current mismatch detector
// Assumes: samples are 24-bit two's complement
// Notes:   state structs follow the one-struct-per-module style
package ncmd_pkg;

    typedef logic signed [23:0] ncmd_sample_t;
    typedef logic signed [27:0] ncmd_word28_t;

    typedef struct packed {
        ncmd_word28_t sum;
        ncmd_sample_t neutral;
        ncmd_sample_t thr;
        logic done_flag;
        logic mis_flag;
        logic mis_mask;
        logic start;
        logic rd_valid;
        logic [31:0] rdata;
    } ncmd_top_state_t;

    typedef struct packed {
        logic hit;
        logic valid;
    } ncmd_cmp_state_t;

endpackage

// ===== ncmd_cmp_if.sv
// Purpose: carries one comparison request and its result
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, valid answers one cycle later
`timescale 1ns/1ns
interface ncmd_cmp_if;
    import ncmd_pkg::*;
    ncmd_word28_t sum;
    ncmd_sample_t neutral;
    ncmd_sample_t thr;
    logic start;
    logic hit;
    logic valid;
    modport ctrl(output sum, output neutral, output thr, output start, input hit, input valid);
    modport cmp(input sum, input neutral, input thr, input start, output hit, output valid);
endinterface

// ===== ncmd_compare.sv
// Purpose: magnitude difference of sum and neutral against the threshold
// Assumes: inputs stable while start is high
// Notes:   result registered one cycle after start
`timescale 1ns/1ns
module ncmd_compare import ncmd_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    ncmd_cmp_if.cmp bus
);

    ncmd_cmp_state_t st;
    ncmd_cmp_state_t next_st;
    logic [27:0] sum_mag;
    logic [27:0] neu_mag;
    logic [27:0] diff;
    ncmd_word28_t thr28;

    function automatic logic [27:0] mag28(input logic signed [27:0] v);
        mag28 = v[27] ? 28'(-v) : 28'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // (RL8) unscaled samples
        sum_mag = mag28(bus.sum);
        neu_mag = mag28({{4{bus.neutral[23]}}, bus.neutral});
        diff = (sum_mag >= neu_mag) ? (sum_mag - neu_mag) : (neu_mag - sum_mag);
        // (RL11) threshold sign extension
        thr28 = {{4{bus.thr[23]}}, bus.thr};
        next_st.valid = bus.start;
        if (bus.start) begin
            // (RL4) strict greater compare
            // (RL7) non-positive always hits
            next_st.hit = (thr28 <= 28'sd0) || (diff > 28'(thr28));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.hit = st.hit;
    assign bus.valid = st.valid;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_nonpos_thr_hits;
        bus.start && (bus.thr <= 24'sd0) |=> bus.valid && bus.hit;
    endproperty
    a_nonpos_thr_hits: assert property (p_nonpos_thr_hits) else $error("non-positive threshold missed"); // RL7

    property p_equal_no_hit;
        bus.start && (bus.thr > 24'sd0) && (bus.sum == {{4{bus.neutral[23]}}, bus.neutral}) |=> !bus.hit;
    endproperty
    a_equal_no_hit: assert property (p_equal_no_hit) else $error("hit raised for matching currents"); // RL4

endmodule

// ===== ncmd_top.sv
// Purpose: neutral current mismatch detector with its status registers
// Assumes: one SAMPLE_VALID pulse per current sample period (8 kHz)
// Notes:   register port is the word side of the serial interface
//
// Summary of operation
// (RL1) add three phase samples into a readable 28-bit signed sum
// (RL2) recompute the sum once per sample period, on each new sample
// (RL3) set computation done flag, bit 17 of first status register
// (RL4) flag mismatch, bit 20, when magnitude difference exceeds threshold
// (RL5) with mask bit 20 set, mismatch drives second interrupt pin low
// (RL6) writing 1 to status bit 20 clears flag and releases pin
// (RL7) threshold is 24-bit signed, reset zero; zero or negative always flags
// (RL8) threshold uses the current ADC scale, 0x5A7540 is full scale
// (RL9) host should program a positive threshold up to 0x7FFFFF after reset
// (RL10) sum reads as 32-bit word with four top bits zero
// (RL11) threshold reads with top four bits zero, sign extended to 28
// (RL12) compare every sample; mismatch flag stays set until host clears it
`timescale 1ns/1ns
`include "ncmd_regs.svh"
module ncmd_top import ncmd_pkg::*; (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SAMPLE_VALID,
    input wire logic [23:0] PHASE_A_CURRENT_SAMPLE,
    input wire logic [23:0] PHASE_B_CURRENT_SAMPLE,
    input wire logic [23:0] PHASE_C_CURRENT_SAMPLE,
    input wire logic [23:0] NEUTRAL_CURRENT_SAMPLE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RD_VALID,
    output logic SECOND_INTERRUPT_PIN_N
);

    ncmd_top_state_t st;
    ncmd_top_state_t next_st;
    ncmd_cmp_if cmp_bus();
    logic clr_done;
    logic clr_mis;
    logic [27:0] thr_ext;

    function automatic ncmd_word28_t sext28(input logic [23:0] v);
        sext28 = {{4{v[23]}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // comparison engine

    ncmd_compare u_compare (
        .clk(CLK),
        .sys_rst(SYS_RST),
        .bus(cmp_bus)
    );

    assign cmp_bus.sum = st.sum;
    assign cmp_bus.neutral = st.neutral;
    assign cmp_bus.thr = st.thr;
    assign cmp_bus.start = st.start;

    ////////////////////////////////////////////////////////////////////////
    // next state

    assign clr_done = REG_WR && (REG_ADDR == `NCMD_ADDR_FIRST_STATUS) && REG_WDATA[`NCMD_DONE_BIT];
    assign clr_mis = REG_WR && (REG_ADDR == `NCMD_ADDR_SECOND_STATUS) && REG_WDATA[`NCMD_MIS_BIT];
    assign thr_ext = sext28(st.thr);

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.rd_valid = 1'b0;

        // (RL2) one update per sample
        if (SAMPLE_VALID) begin
            // (RL1) three-way signed sum
            next_st.sum = sext28(PHASE_A_CURRENT_SAMPLE) + sext28(PHASE_B_CURRENT_SAMPLE)
                + sext28(PHASE_C_CURRENT_SAMPLE);
            next_st.neutral = NEUTRAL_CURRENT_SAMPLE;
            // (RL12) compare every sample
            next_st.start = 1'b1;
        end

        if (REG_WR) begin
            case (REG_ADDR)
                `NCMD_ADDR_THR: begin
                    // (RL7) low 24 bits hold threshold
                    next_st.thr = REG_WDATA[23:0];
                end
                `NCMD_ADDR_SECOND_MASK: begin
                    next_st.mis_mask = REG_WDATA[`NCMD_MIS_BIT];
                end
                default: begin
                end
            endcase
        end

        // write-one-to-clear, a same-cycle set wins
        if (clr_done) begin
            next_st.done_flag = 1'b0;
        end
        // (RL6) host clear of mismatch
        if (clr_mis) begin
            next_st.mis_flag = 1'b0;
        end

        // (RL3) fresh sum available
        if (SAMPLE_VALID) begin
            next_st.done_flag = 1'b1;
        end
        // (RL12) sticky mismatch set
        if (cmp_bus.valid && cmp_bus.hit) begin
            next_st.mis_flag = 1'b1;
        end

        if (REG_RD) begin
            next_st.rd_valid = 1'b1;
            case (REG_ADDR)
                `NCMD_ADDR_SUM: begin
                    // (RL10) top nibble zero
                    next_st.rdata = {`NCMD_PAD4, st.sum};
                end
                `NCMD_ADDR_THR: begin
                    // (RL11) padded sign-extended threshold
                    next_st.rdata = {`NCMD_PAD4, thr_ext};
                end
                `NCMD_ADDR_FIRST_STATUS: begin
                    next_st.rdata = 32'(st.done_flag) << `NCMD_DONE_BIT;
                end
                `NCMD_ADDR_SECOND_STATUS: begin
                    next_st.rdata = 32'(st.mis_flag) << `NCMD_MIS_BIT;
                end
                `NCMD_ADDR_SECOND_MASK: begin
                    next_st.rdata = 32'(st.mis_mask) << `NCMD_MIS_BIT;
                end
                default: begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st.sum <= `NCMD_SUM_RESET;
            st.neutral <= 24'h000000;
            st.thr <= `NCMD_THR_RESET;
            st.done_flag <= 1'b0;
            st.mis_flag <= 1'b0;
            st.mis_mask <= 1'b0;
            st.start <= 1'b0;
            st.rd_valid <= 1'b0;
            st.rdata <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign REG_RDATA = st.rdata;
    assign REG_RD_VALID = st.rd_valid;
    // (RL5) masked mismatch pulls pin low
    assign SECOND_INTERRUPT_PIN_N = ~(st.mis_flag & st.mis_mask);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_sum_value;
        SAMPLE_VALID |=> st.sum == sext28($past(PHASE_A_CURRENT_SAMPLE)) + sext28($past(PHASE_B_CURRENT_SAMPLE))
            + sext28($past(PHASE_C_CURRENT_SAMPLE));
    endproperty
    a_sum_value: assert property (p_sum_value) else $error("phase current sum wrong"); // RL1

    sequence s_compare_run;
        cmp_bus.start ##1 cmp_bus.valid;
    endsequence

    property p_sample_compare;
        SAMPLE_VALID |=> s_compare_run;
    endproperty
    a_sample_compare: assert property (p_sample_compare) else $error("sample did not start a compare"); // RL2

    property p_done_set;
        SAMPLE_VALID |=> st.done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set after sample"); // RL3

    property p_mis_set;
        cmp_bus.valid && cmp_bus.hit |=> st.mis_flag;
    endproperty
    a_mis_set: assert property (p_mis_set) else $error("mismatch flag not set on hit"); // RL4

    property p_irq_low;
        $rose(st.mis_flag) && st.mis_mask |-> !SECOND_INTERRUPT_PIN_N;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt pin not low on mismatch"); // RL5

    property p_clear;
        clr_mis && !(cmp_bus.valid && cmp_bus.hit) |=> !st.mis_flag && SECOND_INTERRUPT_PIN_N;
    endproperty
    a_clear: assert property (p_clear) else $error("mismatch clear failed"); // RL6

    property p_sticky;
        st.mis_flag && !clr_mis |=> st.mis_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("mismatch flag dropped without clear"); // RL12

    property p_sum_read;
        REG_RD && (REG_ADDR == `NCMD_ADDR_SUM) |=> REG_RD_VALID && (REG_RDATA[31:28] == `NCMD_PAD4)
            && (REG_RDATA[27:0] == $past(st.sum));
    endproperty
    a_sum_read: assert property (p_sum_read) else $error("sum readback wrong"); // RL10

    sequence s_thr_write_read;
        REG_WR && (REG_ADDR == `NCMD_ADDR_THR) ##1 REG_RD && !REG_WR && (REG_ADDR == `NCMD_ADDR_THR);
    endsequence

    property p_thr_read;
        s_thr_write_read |=> REG_RDATA == {`NCMD_PAD4, {4{$past(REG_WDATA[23], 2)}}, $past(REG_WDATA[23:0], 2)};
    endproperty
    a_thr_read: assert property (p_thr_read) else $error("threshold readback wrong"); // RL11

endmodule

// ===== ncmd_host.sv
// Purpose: host side of the register port, word reads and writes
// Assumes: one-cycle strobes, read answer exactly one cycle after the strobe
// Notes: released address and data are driven inverted, never left at the old value
`timescale 1ns/1ns
module ncmd_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rd_valid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h00000000;
    end

    task automatic write_word(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic read_word(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 32'hxxxxxxxx;
    endtask

    // write then read the same word on the next cycle, back to back
    task automatic write_read_word(input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_wdata = ~d;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        q = (reg_rd_valid === 1'b1) ? reg_rdata : 32'hxxxxxxxx;
    endtask
endmodule

// ===== testbench.sv
// Purpose: self-checking bench of the mismatch detector
// Assumes: inputs change 1 ns after the rising edge
// Notes: flags are read three cycles after a sample
`timescale 1ns/1ns
`include "ncmd_regs.svh"
module testbench;
    logic CLK, SYS_RST, SAMPLE_VALID, REG_WR, REG_RD, REG_RD_VALID, PIN_N;
    logic [23:0] A, B, C, N;
    logic [15:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd_word;
    logic [23:0] nv [3] = '{24'h000200, 24'hfffe00, 24'h0001ff};
    logic [31:0] fv [3] = '{32'h0, 32'h0, 32'h00100000};

    ncmd_top ncmd_top_i (.CLK(CLK), .SYS_RST(SYS_RST), .SAMPLE_VALID(SAMPLE_VALID),
        .PHASE_A_CURRENT_SAMPLE(A), .PHASE_B_CURRENT_SAMPLE(B), .PHASE_C_CURRENT_SAMPLE(C),
        .NEUTRAL_CURRENT_SAMPLE(N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RD_VALID(REG_RD_VALID),
        .SECOND_INTERRUPT_PIN_N(PIN_N));
    ncmd_host ncmd_host_i (.clk(CLK), .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
        .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA), .reg_rd_valid(REG_RD_VALID));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ncmd_host_i.read_word(a, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        ncmd_host_i.write_word(a, d);
    endtask

    // returns 1 ns after the rising edge that takes the sample
    task automatic smp(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
                       input logic [23:0] n);
        @(posedge CLK);
        #1;
        SAMPLE_VALID = 1'b1;
        A = a;
        B = b;
        C = c;
        N = n;
        @(posedge CLK);
        #1;
        SAMPLE_VALID = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        SYS_RST = 1'b1;
        SAMPLE_VALID = 1'b0;
        {A, B, C, N} = '0;
        repeat (5) @(posedge CLK);
        #1;
        SYS_RST = 1'b0;
        rchk(`NCMD_ADDR_THR, 32'h00000000);
        rchk(`NCMD_ADDR_SECOND_MASK, 32'h00000000);
        rchk(16'h00ff, 32'h00000000);
        smp(24'h000010, 24'h000000, 24'h000000, 24'h000010);
        repeat (3) @(posedge CLK);
        rchk(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        chk({31'h0, PIN_N}, 32'h1);
        wr(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        rchk(`NCMD_ADDR_SECOND_STATUS, 32'h00000000);
        $display("test reset_threshold done");
        smp(24'h000123, 24'h000001, 24'h000002, 24'h000000);
        smp(24'h7fffff, 24'h7fffff, 24'h7fffff, 24'h000000);
        rchk(`NCMD_ADDR_SUM, 32'h017ffffd);
        rchk(`NCMD_ADDR_FIRST_STATUS, 32'h00020000);
        wr(`NCMD_ADDR_FIRST_STATUS, 32'h00020000);
        rchk(`NCMD_ADDR_FIRST_STATUS, 32'h00000000);
        smp(24'h800000, 24'h800000, 24'h800000, 24'h000000);
        wr(`NCMD_ADDR_SUM, 32'h00000000);
        rchk(`NCMD_ADDR_SUM, 32'h0e800000);
        $display("test phase_sum done");
        wr(`NCMD_ADDR_THR, 32'h005a7540);
        rchk(`NCMD_ADDR_THR, 32'h005a7540);
        ncmd_host_i.write_read_word(`NCMD_ADDR_THR, 32'h00800000, rd_word);
        chk(rd_word, 32'h0f800000);
        wr(`NCMD_ADDR_THR, 32'h00000100);
        wr(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        for (int i = 0; i < 3; i++) begin
            smp(24'h000300, 24'h000000, 24'h000000, nv[i]);
            repeat (3) @(posedge CLK);
            rchk(`NCMD_ADDR_SECOND_STATUS, fv[i]);
        end
        wr(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        $display("test threshold_compare done");
        wr(`NCMD_ADDR_SECOND_MASK, 32'h00100000);
        rchk(`NCMD_ADDR_SECOND_MASK, 32'h00100000);
        smp(24'h000400, 24'h000000, 24'h000000, 24'h000000);
        @(posedge CLK);
        #1;
        chk({31'h0, PIN_N}, 32'h1);
        @(posedge CLK);
        #1;
        chk({31'h0, PIN_N}, 32'h0);
        smp(24'h000010, 24'h000000, 24'h000000, 24'h000010);
        repeat (3) @(posedge CLK);
        rchk(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        chk({31'h0, PIN_N}, 32'h0);
        wr(`NCMD_ADDR_SECOND_STATUS, 32'h00100000);
        chk({31'h0, PIN_N}, 32'h1);
        wr(`NCMD_ADDR_THR, 32'h00ffffff);
        smp(24'h000010, 24'h000000, 24'h000000, 24'h000010);
        repeat (3) @(posedge CLK);
        #1;
        chk({31'h0, PIN_N}, 32'h0);
        $display("test interrupt_pin done");
        end_of_test();
    end
endmodule
